// ==== verilog/hs_sequencer.sv ====
// Homing sequencer: method planning, switch/stall events, object registers
// Function
// - Fast search speed, slow zero speed held
// - One acceleration for every homing ramp
// - Stall needs torque at or above threshold
// - Stall only after dwell in 0.125ms steps
// - Stall: -4/-3 reverse to index; -2/-1 origin
// - Method 1 clear: fast negative, back slow
// - Method 1 set: slow positive to index
// - Method 2 clear: fast positive, back slow
// - Method 2 set: slow negative to index
// - Method 3 clear: fast positive, back slow
// - Method 3 set: slow negative to index
// - Method 4 clear: slow positive to index
// - Method 4 set: fast negative, back slow
// - Start bit edges start/interrupt; halt stops axis
// - Status bits: attained, error, target reached
// - Load position with home offset at origin
`timescale 1ns/1ps
`default_nettype none
module hs_sequencer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Control word from the fieldbus master
  input wire logic [15:0] control_word,
  // Object dictionary access
  input wire logic od_wr,
  input wire logic [15:0] od_index,
  input wire logic [7:0] od_sub,
  input wire logic [31:0] od_wdata,
  output logic [31:0] od_rdata,
  // Switch and encoder pins (asynchronous)
  input wire hs_pkg::hs_sw_t sw_pins,
  // Drive feedback on this clock
  input wire logic [15:0] torque_pct,
  input wire logic motion_stopped,
  // Outputs
  output hs_pkg::hs_move_t move_cmd,
  output logic pos_load,
  output logic [31:0] pos_load_value,
  output logic [15:0] status_word
);
  import hs_pkg::*;

  localparam logic [10:0] TICK_LAST = 11'(HS_DWELL_STEP_CYC - 1);

  // All state of the block
  typedef struct packed {
    logic [2:0][3:0] sync;   // Three-stage synchronisers, stage 0 first
    logic [3:0] stable;      // Agreed switch levels
    hs_state_t state;
    hs_phase_t cur;          // Phase being run
    hs_phase_t nxt;          // Phase to run after it
    logic have_nxt;
    logic armed;             // Switch edge seen, waiting for index
    logic [10:0] tick_cnt;   // Dwell step divider
    logic [15:0] dwell_cnt;  // Steps the torque has held
    logic cw_start_d;        // Previous start bit
    logic attained;
    logic error;
    logic pos_load;
    logic [15:0] stall_torque_threshold;
    logic [15:0] stall_dwell_time;
    logic [31:0] homing_fast_search_speed;
    logic [31:0] homing_slow_zero_speed;
    logic [31:0] homing_ramp_acceleration;
    logic [31:0] home_offset;
    logic [7:0] homing_method;
    logic [31:0] rdata;
  } hs_regs_t;

  localparam hs_regs_t HS_RESET = '{
    state: HS_IDLE,
    stall_torque_threshold: HS_RST_STALL_THRESH,
    stall_dwell_time: HS_RST_STALL_DWELL,
    homing_fast_search_speed: HS_RST_FAST,
    homing_slow_zero_speed: HS_RST_SLOW,
    homing_ramp_acceleration: HS_RST_ACCEL,
    home_offset: HS_RST_OFFSET,
    homing_method: HS_RST_METHOD,
    default: '0
  };

  hs_regs_t s;
  hs_regs_t next_s;

  // ----------------------------------------------------------------
  // Phase builder
  // ----------------------------------------------------------------
  // Packs one phase description; keeps the method table readable
  function automatic hs_phase_t ph(input logic dir_pos, input logic fast,
                                   input logic rise, input logic index,
                                   input logic stall, input logic pre_arm,
                                   input logic [1:0] sel);
    ph = '{dir_pos: dir_pos, fast: fast, rise: rise, index: index,
           stall: stall, pre_arm: pre_arm, sel: sel};
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  logic [3:0] rise_ev;     // One-cycle switch rise events
  logic [3:0] fall_ev;     // One-cycle switch fall events
  logic edge_hit;          // Wanted edge on the watched switch
  logic stall_hit;         // Torque has stalled long enough
  logic phase_end;         // Current phase reached its event
  logic start_req;         // 0 -> 1 of the start bit
  logic halt;

  always_comb begin
    next_s = s;
    next_s.pos_load = 1'b0;
    halt = control_word[HS_CW_HALT];
    start_req = control_word[HS_CW_START] & ~s.cw_start_d;
    next_s.cw_start_d = control_word[HS_CW_START];

    // Synchronisers; a change counts once stages 1 and 2 agree
    next_s.sync[0] = sw_pins;
    next_s.sync[1] = s.sync[0];
    next_s.sync[2] = s.sync[1];
    for (int i = 0; i < 4; i++) begin
      rise_ev[i] = 1'b0;
      fall_ev[i] = 1'b0;
      if (s.sync[1][i] == s.sync[2][i]) begin
        // Edge flagged only against the held level, so once per change
        rise_ev[i] = s.sync[1][i] & ~s.stable[i];
        fall_ev[i] = ~s.sync[1][i] & s.stable[i];
        next_s.stable[i] = s.sync[1][i];
      end
    end

    // Dwell step divider: one enable per 0.125 ms
    if (s.tick_cnt == TICK_LAST) begin
      next_s.tick_cnt = '0;
    end else begin
      next_s.tick_cnt = s.tick_cnt + 11'h001;
    end

    // Stall filter counts steps while torque holds at threshold
    if (torque_pct < s.stall_torque_threshold || s.state != HS_SEEK) begin
      next_s.dwell_cnt = '0;
    end else if (s.tick_cnt == TICK_LAST && s.dwell_cnt != 16'hffff) begin
      next_s.dwell_cnt = s.dwell_cnt + 16'h0001;
    end
    stall_hit = torque_pct >= s.stall_torque_threshold &&
                s.dwell_cnt >= s.stall_dwell_time;

    // Event that ends the running phase
    edge_hit = s.cur.rise ? rise_ev[s.cur.sel] : fall_ev[s.cur.sel];
    if (s.cur.stall) begin
      phase_end = stall_hit;
    end else if (s.cur.index) begin
      // Index counts only after the switch edge armed the phase, or at once when pre_arm is set
      phase_end = (s.armed | s.cur.pre_arm) & rise_ev[3];
      if (edge_hit) begin
        next_s.armed = 1'b1;
      end
    end else begin
      phase_end = edge_hit;
    end

    // Sequencer
    case (s.state)
      HS_IDLE, HS_DONE: begin
        if (start_req) begin
          // Flags clear on every new run
          next_s.attained = 1'b0;
          next_s.error = 1'b0;
          next_s.armed = 1'b0;
          next_s.have_nxt = 1'b0;
          next_s.state = HS_SEEK;
          case (s.homing_method)
            8'h01: begin
              next_s.nxt = ph(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, HS_SEL_NEG);
              if (!s.stable[0]) begin
                next_s.cur = ph(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, HS_SEL_NEG);
                next_s.have_nxt = 1'b1;
              end else begin
                next_s.cur = next_s.nxt;
              end
            end
            8'h02: begin
              next_s.nxt = ph(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, HS_SEL_POS);
              if (!s.stable[1]) begin
                next_s.cur = ph(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, HS_SEL_POS);
                next_s.have_nxt = 1'b1;
              end else begin
                next_s.cur = next_s.nxt;
              end
            end
            8'h03: begin
              next_s.nxt = ph(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, HS_SEL_HOME);
              if (!s.stable[2]) begin
                next_s.cur = ph(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, HS_SEL_HOME);
                next_s.have_nxt = 1'b1;
              end else begin
                next_s.cur = next_s.nxt;
              end
            end
            8'h04: begin
              if (!s.stable[2]) begin
                next_s.cur = ph(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, HS_SEL_HOME);
              end else begin
                next_s.cur = ph(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, HS_SEL_HOME);
                next_s.nxt = ph(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, HS_SEL_HOME);
                next_s.have_nxt = 1'b1;
              end
            end
            8'hfc, 8'hfd: begin
              // Run into the stop, then reverse slowly to the next index
              next_s.cur = ph(~s.homing_method[0], 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, HS_SEL_HOME);
              next_s.nxt = ph(s.homing_method[0], 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, HS_SEL_HOME);
              next_s.have_nxt = 1'b1;
            end
            8'hfe, 8'hff: begin
              // Stall point itself is the origin
              next_s.cur = ph(~s.homing_method[0], 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, HS_SEL_HOME);
            end
            default: begin
              // Methods not served here report a homing error
              next_s.error = 1'b1;
              next_s.state = HS_IDLE;
            end
          endcase
        end
      end
      HS_SEEK: begin
        if (phase_end) begin
          if (s.have_nxt) begin
            next_s.cur = s.nxt;
            next_s.have_nxt = 1'b0;
            next_s.armed = 1'b0;
          end else begin
            next_s.state = HS_STOP;
          end
        end
      end
      HS_STOP: begin
        // Origin declared only once the axis is at rest
        if (motion_stopped && !halt) begin
          next_s.attained = 1'b1;
          next_s.pos_load = 1'b1;
          next_s.state = HS_DONE;
        end
      end
      default: begin
        next_s.state = HS_IDLE;
      end
    endcase

    // Falling start bit interrupts a run in progress
    if (!control_word[HS_CW_START] && s.cw_start_d &&
        (s.state == HS_SEEK || s.state == HS_STOP)) begin
      next_s.state = HS_IDLE;
      next_s.pos_load = 1'b0;
      // Rest reported on the abort edge must not leave a success flag behind
      next_s.attained = 1'b0;
    end

    // Object writes; the method code is a signed byte
    if (od_wr) begin
      if (od_index == HS_IDX_STALL_THRESH && od_sub == HS_SUB_MAIN) begin
        next_s.stall_torque_threshold = od_wdata[15:0];
      end else if (od_index == HS_IDX_STALL_DWELL && od_sub == HS_SUB_MAIN) begin
        next_s.stall_dwell_time = od_wdata[15:0];
      end else if (od_index == HS_IDX_SPEEDS && od_sub == HS_SUB_FAST) begin
        next_s.homing_fast_search_speed = od_wdata;
      end else if (od_index == HS_IDX_SPEEDS && od_sub == HS_SUB_SLOW) begin
        next_s.homing_slow_zero_speed = od_wdata;
      end else if (od_index == HS_IDX_ACCEL && od_sub == HS_SUB_MAIN) begin
        next_s.homing_ramp_acceleration = od_wdata;
      end else if (od_index == HS_IDX_OFFSET && od_sub == HS_SUB_MAIN) begin
        next_s.home_offset = od_wdata;
      end else if (od_index == HS_IDX_METHOD && od_sub == HS_SUB_MAIN) begin
        next_s.homing_method = od_wdata[7:0];
      end
    end

    // Read data registered; unknown objects read as zero
    if (od_index == HS_IDX_STALL_THRESH && od_sub == HS_SUB_MAIN) begin
      next_s.rdata = {16'h0000, s.stall_torque_threshold};
    end else if (od_index == HS_IDX_STALL_DWELL && od_sub == HS_SUB_MAIN) begin
      next_s.rdata = {16'h0000, s.stall_dwell_time};
    end else if (od_index == HS_IDX_SPEEDS && od_sub == HS_SUB_FAST) begin
      next_s.rdata = s.homing_fast_search_speed;
    end else if (od_index == HS_IDX_SPEEDS && od_sub == HS_SUB_SLOW) begin
      next_s.rdata = s.homing_slow_zero_speed;
    end else if (od_index == HS_IDX_ACCEL && od_sub == HS_SUB_MAIN) begin
      next_s.rdata = s.homing_ramp_acceleration;
    end else if (od_index == HS_IDX_OFFSET && od_sub == HS_SUB_MAIN) begin
      next_s.rdata = s.home_offset;
    end else if (od_index == HS_IDX_METHOD && od_sub == HS_SUB_MAIN) begin
      next_s.rdata = {{24{s.homing_method[7]}}, s.homing_method};
    end else if (od_index == HS_IDX_STATUS && od_sub == HS_SUB_MAIN) begin
      next_s.rdata = {16'h0000, status_word};
    end else begin
      next_s.rdata = '0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= HS_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Halt drops the move request; the ramp uses the homing acceleration
  always_comb begin
    move_cmd.en = (s.state == HS_SEEK) && !halt;
    move_cmd.dir_pos = s.cur.dir_pos;
    move_cmd.speed = s.cur.fast ? s.homing_fast_search_speed
                                : s.homing_slow_zero_speed;
    move_cmd.accel = s.homing_ramp_acceleration;
    status_word = '0;
    status_word[HS_SW_ATTAINED] = s.attained;
    status_word[HS_SW_ERROR] = s.error;
    status_word[HS_SW_REACHED] = halt ? motion_stopped : s.attained;
  end

  assign pos_load = s.pos_load;
  assign pos_load_value = s.home_offset;
  assign od_rdata = s.rdata;
endmodule
`default_nettype wire

// ==== verilog/hs_pkg.sv ====
// Package: constants and types for the servo homing sequencer
package hs_pkg;
  // ----------------------------------------------------------------
  // Object indices and subindices
  // ----------------------------------------------------------------
  localparam logic [15:0] HS_IDX_STALL_THRESH = 16'h3049;
  localparam logic [15:0] HS_IDX_STALL_DWELL = 16'h304a;
  localparam logic [15:0] HS_IDX_SPEEDS = 16'h6099;
  localparam logic [15:0] HS_IDX_ACCEL = 16'h609a;
  localparam logic [15:0] HS_IDX_OFFSET = 16'h607c;
  localparam logic [15:0] HS_IDX_METHOD = 16'h6098;
  localparam logic [15:0] HS_IDX_STATUS = 16'h6041;
  localparam logic [7:0] HS_SUB_MAIN = 8'h00;
  localparam logic [7:0] HS_SUB_FAST = 8'h01;
  localparam logic [7:0] HS_SUB_SLOW = 8'h02;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] HS_RST_STALL_THRESH = 16'h0014;
  localparam logic [15:0] HS_RST_STALL_DWELL = 16'h0064;
  localparam logic [31:0] HS_RST_FAST = 32'h0000_1388;
  localparam logic [31:0] HS_RST_SLOW = 32'h0000_0064;
  localparam logic [31:0] HS_RST_ACCEL = 32'h0001_86a0;
  localparam logic [31:0] HS_RST_OFFSET = 32'h0000_0000;
  localparam logic [7:0] HS_RST_METHOD = 8'h01;
  // ----------------------------------------------------------------
  // Control and status word bit positions
  // ----------------------------------------------------------------
  localparam int HS_CW_START = 4;
  localparam int HS_CW_HALT = 8;
  localparam int HS_SW_REACHED = 10;
  localparam int HS_SW_ATTAINED = 12;
  localparam int HS_SW_ERROR = 13;
  // ----------------------------------------------------------------
  // Timing: dwell step of 0.125 ms at a 100 ns clock
  // ----------------------------------------------------------------
  localparam int HS_CLK_PERIOD_NS = 100;
  localparam int HS_DWELL_STEP_NS = 125000;
  localparam int HS_DWELL_STEP_CYC = HS_DWELL_STEP_NS / HS_CLK_PERIOD_NS;
  // Switch selectors inside a move phase
  localparam logic [1:0] HS_SEL_NEG = 2'h0;
  localparam logic [1:0] HS_SEL_POS = 2'h1;
  localparam logic [1:0] HS_SEL_HOME = 2'h2;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_SEEK = 2'b01,
    HS_STOP = 2'b10,
    HS_DONE = 2'b11
  } hs_state_t;
  // One move phase: where to go and which event ends it
  typedef struct packed {
    logic dir_pos;   // 1 = positive direction
    logic fast;      // Use switch search speed
    logic rise;      // Switch edge wanted: 1 rising, 0 falling
    logic index;     // End on first index pulse after the edge
    logic stall;     // End on torque stall instead of a switch
    logic pre_arm;   // Index may end the phase at once
    logic [1:0] sel; // Which switch is watched
  } hs_phase_t;
  // Switch inputs: negative limit, positive limit, home, index
  typedef struct packed {
    logic idx;
    logic home;
    logic pos;
    logic neg;
  } hs_sw_t;
  // Axis command to the motion profile generator
  typedef struct packed {
    logic en;
    logic dir_pos;
    logic [31:0] speed;
    logic [31:0] accel;
  } hs_move_t;
endpackage

// ==== verification/hs_sequencer_sva.sv ====
// Checker: concurrent properties on the homing sequencer ports
`timescale 1ns/1ps
`default_nettype none
module hs_sequencer_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Master and object bus
  input wire logic [15:0] control_word,
  input wire logic od_wr,
  input wire logic [15:0] od_index,
  input wire logic [7:0] od_sub,
  input wire logic [31:0] od_wdata,
  input wire logic [31:0] od_rdata,
  // Pins and drive feedback
  input wire hs_pkg::hs_sw_t sw_pins,
  input wire logic [15:0] torque_pct,
  input wire logic motion_stopped,
  // Design outputs
  input wire hs_pkg::hs_move_t move_cmd,
  input wire logic pos_load,
  input wire logic [31:0] pos_load_value,
  input wire logic [15:0] status_word
);
  import hs_pkg::*;
  // ---------------------------------------------
  // Shadow objects, written on the same edge as the design's
  // ---------------------------------------------
  logic [31:0] sh_fast, sh_slow, sh_acc, sh_off;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sh_fast <= HS_RST_FAST;
      sh_slow <= HS_RST_SLOW;
      sh_acc <= HS_RST_ACCEL;
      sh_off <= HS_RST_OFFSET;
    end else if (od_wr) begin
      if (od_index == HS_IDX_SPEEDS && od_sub == HS_SUB_FAST) sh_fast <= od_wdata;
      if (od_index == HS_IDX_SPEEDS && od_sub == HS_SUB_SLOW) sh_slow <= od_wdata;
      if (od_index == HS_IDX_ACCEL && od_sub == HS_SUB_MAIN) sh_acc <= od_wdata;
      if (od_index == HS_IDX_OFFSET && od_sub == HS_SUB_MAIN) sh_off <= od_wdata;
    end
  end
  // ---------------------------------------------
  // Properties
  // ---------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_HALT_STILL: assert property (
    control_word[HS_CW_HALT] |-> !move_cmd.en) else $error("axis moves while halted");
  AST_DROP_ON_CLEAR: assert property (
    $fell(control_word[HS_CW_START]) |=> !move_cmd.en) else $error("move kept after abort");
  AST_EN_NEEDS_START: assert property (
    $rose(move_cmd.en) |-> control_word[HS_CW_START]) else $error("move without start");
  AST_NO_ATTAIN_ABORT: assert property (
    $fell(control_word[HS_CW_START]) && !status_word[HS_SW_ATTAINED] |=>
    (!status_word[HS_SW_ATTAINED]) [*2])
    else $error("attained after abort");
  AST_ACCEL: assert property (
    move_cmd.en |-> move_cmd.accel == sh_acc) else $error("ramp not homing accel");
  AST_SPEED: assert property (
    move_cmd.en |-> move_cmd.speed == sh_fast || move_cmd.speed == sh_slow)
    else $error("speed is neither homing speed");
  AST_LOAD: assert property (
    pos_load |-> pos_load_value == sh_off ##1 !pos_load) else $error("bad position load");
  AST_ATTAIN_STOP: assert property (
    $rose(status_word[HS_SW_ATTAINED]) |-> $past(motion_stopped) && !move_cmd.en && pos_load)
    else $error("attained before full stop");
  AST_REACHED_HALT: assert property (
    control_word[HS_CW_HALT] && motion_stopped |-> status_word[HS_SW_REACHED])
    else $error("no reached flag at halt standstill");
  AST_ERR_EXCL: assert property (
    status_word[HS_SW_ERROR] |-> !status_word[HS_SW_ATTAINED] && !move_cmd.en)
    else $error("error together with success or motion");
endmodule
bind hs_sequencer hs_sequencer_sva u_sva (.clk(clk), .rst_b(rst_b),
  .control_word(control_word), .od_wr(od_wr), .od_index(od_index), .od_sub(od_sub),
  .od_wdata(od_wdata), .od_rdata(od_rdata), .sw_pins(sw_pins), .torque_pct(torque_pct),
  .motion_stopped(motion_stopped), .move_cmd(move_cmd), .pos_load(pos_load),
  .pos_load_value(pos_load_value), .status_word(status_word));
`default_nettype wire

// ==== verification/hs_master_model.sv ====
// Fieldbus master model: owns the control word seen by the sequencer
`timescale 1ns/1ps
`default_nettype none
module hs_master_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Requests from the test sequence
  input wire logic go,
  input wire logic halt,
  // Control word to the drive
  output logic [15:0] control_word
);
  import hs_pkg::*;
  // Refreshed once a cycle; only start and halt are used in homing
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      control_word <= 16'h0000;
    end else begin
      // One assignment a cycle; all other bits stay zero
      control_word <= (16'(go) << HS_CW_START) | (16'(halt) << HS_CW_HALT);
    end
  end
endmodule
`default_nettype wire

// ==== verification/servo_homing_sequencer_tb.sv ====
// Testbench: self-checking regression of the homing sequencer
`timescale 1ns/1ps
`default_nettype none
module servo_homing_sequencer_tb;
  import hs_pkg::*;
  // ---------------------------------------------
  // Signals and model state
  // ---------------------------------------------
  logic clk, rst_b, go, halt, od_wr, stopped, pos_load;
  logic [15:0] cw, od_index, torque, st;
  logic [7:0] od_sub;
  logic [31:0] od_wdata, od_rdata, lval, lv_seen, seed, rd;
  hs_sw_t sw;
  hs_move_t mv;
  int n_fail, tests_run, n_load, m_fast, m_slow, m_off;
  logic [7:0] codes[$] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'hfc, 8'hfd, 8'hfe, 8'hff};
  logic [15:0] ti [5] = '{16'h3049, 16'h304a, 16'h6099, 16'h6099, 16'h609a};
  logic [7:0] ts [5] = '{8'h00, 8'h00, 8'h01, 8'h02, 8'h00};
  int dv [5] = '{20, 100, 5000, 100, 100000};
  initial clk = 1'b0;
  always #50 clk = ~clk;
  hs_sequencer u_dut (.clk(clk), .rst_b(rst_b), .control_word(cw), .od_wr(od_wr),
    .od_index(od_index), .od_sub(od_sub), .od_wdata(od_wdata), .od_rdata(od_rdata),
    .sw_pins(sw), .torque_pct(torque), .motion_stopped(stopped), .move_cmd(mv),
    .pos_load(pos_load), .pos_load_value(lval), .status_word(st));
  hs_master_model u_master (.clk(clk), .rst_b(rst_b), .go(go), .halt(halt),
    .control_word(cw));
  // Origin loads are counted, a double pulse would show here
  always @(posedge clk) if (pos_load === 1'b1) begin
    n_load++;
    lv_seen = lval;
  end
  // ---------------------------------------------
  // Tasks; checks read values settled before the edge
  // ---------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic od_write(input logic [15:0] i, input logic [7:0] s, input logic [31:0] d);
    @(posedge clk);
    od_wr <= 1'b1;
    od_index <= i;
    od_sub <= s;
    od_wdata <= d;
    @(posedge clk);
    od_wr <= 1'b0;
  endtask
  task automatic od_read(input logic [15:0] i, input logic [7:0] s, output logic [31:0] d);
    @(posedge clk);
    od_index <= i;
    od_sub <= s;
    wt(2);
    d = od_rdata;
  endtask
  task automatic pulse_idx();
    sw.idx <= 1'b1;
    wt(4);
    sw.idx <= 1'b0;
    wt(4);
  endtask
  task automatic start(input logic [7:0] m);
    od_write(HS_IDX_METHOD, HS_SUB_MAIN, {24'h0, m});
    wt(5);
    go <= 1'b1;
    wt(5);
  endtask
  task automatic finish_run();
    go <= 1'b0;
    stopped <= 1'b0;
    torque <= 16'h0000;
    wt(4);
  endtask
  // First move of each method: direction from the code and, for methods 1 to 4, the start switch level
  function automatic logic e_dir(input logic [7:0] c, input logic l);
    if (c[7]) return !c[0];
    return (c == 8'h01) ? l : !l;
  endfunction
  function automatic logic e_fast(input logic [7:0] c, input logic l);
    return c[7] ? 1'b1 : ((c == 8'h04) ? l : !l);
  endfunction
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Watchdog: the sequence needs well under 0.5 ms
  initial begin
    #3_000_000;
    n_fail++;
    give_verdict();
  end
  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial begin
    seed = 32'd43836;
    {rst_b, go, halt, od_wr, stopped} = '0;
    {od_index, od_sub, od_wdata, torque, sw} = '0;
    wt(8);
    rst_b <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      od_read(ti[k], ts[k], rd);
      chk("reset value", dv[k], rd);
    end
    od_write(HS_IDX_STATUS, HS_SUB_MAIN, 32'h0000_ffff);
    od_read(HS_IDX_STATUS, HS_SUB_MAIN, rd);
    chk("status after write", 0, rd);
    m_fast = (xs() & 32'h0000_ffff) | 32'h0001_0000;
    m_slow = xs() & 32'h0000_0fff;
    m_off = xs();
    od_write(HS_IDX_SPEEDS, HS_SUB_FAST, m_fast);
    od_write(HS_IDX_SPEEDS, HS_SUB_SLOW, m_slow);
    od_write(HS_IDX_OFFSET, HS_SUB_MAIN, m_off);
    od_read(HS_IDX_SPEEDS, HS_SUB_FAST, rd);
    chk("fast speed", m_fast, rd);
    foreach (codes[k]) for (int l = 0; l < 2; l++) begin
      sw.neg <= codes[k] == 8'h01 && l[0];
      sw.pos <= codes[k] == 8'h02 && l[0];
      sw.home <= codes[k] > 8'h02 && l[0];
      start(codes[k]);
      chk("enable", 1, mv.en);
      chk("direction", e_dir(codes[k], l[0]), mv.dir_pos);
      chk("speed", e_fast(codes[k], l[0]) ? m_fast : m_slow, mv.speed);
      chk("accel", 100000, mv.accel);
      finish_run();
      chk("abort enable", 0, mv.en);
      chk("abort attained", 0, st[HS_SW_ATTAINED]);
    end
    // Full method 1 run with an early index pulse that must not count
    sw <= '0;
    start(8'h01);
    sw.neg <= 1'b1;
    wt(6);
    chk("return dir", 1, mv.dir_pos);
    chk("return speed", m_slow, mv.speed);
    pulse_idx();
    chk("index before fall", 1, mv.en);
    sw.neg <= 1'b0;
    wt(6);
    pulse_idx();
    chk("stop at index", 0, mv.en);
    chk("early attained", 0, st[HS_SW_ATTAINED]);
    stopped <= 1'b1;
    wt(3);
    chk("attained", 1, st[HS_SW_ATTAINED]);
    chk("reached", 1, st[HS_SW_REACHED]);
    chk("loads", 1, n_load);
    chk("load value", m_off, lv_seen);
    finish_run();
    // Halt in mid search, then resume
    start(8'h02);
    halt <= 1'b1;
    wt(4);
    chk("halted", 0, mv.en);
    stopped <= 1'b1;
    wt(3);
    chk("halt standstill", 1, st[HS_SW_REACHED]);
    halt <= 1'b0;
    stopped <= 1'b0;
    wt(4);
    chk("resumed", 1, mv.en);
    finish_run();
    // Stall at the threshold boundary, no dwell
    od_write(HS_IDX_STALL_THRESH, HS_SUB_MAIN, 32'd30);
    od_write(HS_IDX_STALL_DWELL, HS_SUB_MAIN, 32'd0);
    torque <= 16'd29;
    start(8'hfe);
    wt(5);
    chk("below threshold", 1, mv.en);
    torque <= 16'd30;
    wt(5);
    chk("stall stop", 0, mv.en);
    stopped <= 1'b1;
    wt(3);
    chk("stall origin", 1, st[HS_SW_ATTAINED]);
    finish_run();
    // Dwell of two steps of 1250 cycles
    od_write(HS_IDX_STALL_DWELL, HS_SUB_MAIN, 32'd2);
    start(8'hff);
    torque <= 16'd200;
    wt(1200);
    chk("dwell running", 1, mv.en);
    wt(1400);
    chk("dwell over", 0, mv.en);
    // Abort seen on the same edge as the rest report: no success, no load
    go <= 1'b0;
    wt(1);
    stopped <= 1'b1;
    wt(3);
    chk("abort at rest", 0, st[HS_SW_ATTAINED]);
    chk("abort no load", 2, n_load);
    finish_run();
    // Unsupported method code
    start(8'h05);
    chk("method error", 1, st[HS_SW_ERROR]);
    chk("error no move", 0, mv.en);
    finish_run();
    give_verdict();
  end
endmodule
`default_nettype wire
